// file: hdl/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wptr;
  logic [PW:0] rptr;
  logic [PW:0] fill;

  // Extra pointer bit tells full from empty
  assign fill = wptr - rptr;
  assign in_ready = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rptr[PW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
    end else if (in_valid && in_ready) begin
      wptr <= wptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr <= '0;
    end else if (out_valid && out_ready) begin
      rptr <= rptr + 1'b1;
    end
  end

endmodule

// file: hdl/i2c_dual_slave.sv
// Two-wire slave port serving a memory target and a companion register target
`timescale 1ns/1ns
module i2c_dual_slave #(
  parameter logic [3:0] MEM_TYPE = 4'h6, // Arbitrary value
  parameter logic [3:0] REG_TYPE = 4'h9, // Arbitrary value
  parameter int FIFO_DEPTH = i2c_port_pkg::FIFO_DEPTH
) (
  // Clock and supply-level reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Device select straps
  input wire logic [1:0] dev_sel,
  // Read side toward memory and registers
  output logic [i2c_port_pkg::MEM_AW-1:0] mem_addr,
  output logic [i2c_port_pkg::REG_AW-1:0] reg_addr,
  output logic rd_is_reg,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] reg_rdata,
  // Write stream toward memory and registers
  output logic wr_valid,
  input wire logic wr_ready,
  output i2c_port_pkg::wr_item_t wr_item
);
  // ----------------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [1:0] sel_m, sel_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      sel_m <= 2'h0;
      sel_s <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      sel_m <= dev_sel;
      sel_s <= sel_m;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------------
  // Byte engine state
  // ----------------------------------------------------------------------
  i2c_port_pkg::port_state_t state;
  logic [3:0] bcnt;
  logic ack_phase;
  logic [7:0] shift;
  logic [7:0] addr_hi;
  logic rw;
  logic nacked;
  logic fifo_in_ready;

  logic ack_begin, ack_end, sa_match, reg_bad, push, give_ack;
  logic load_mem, load_reg, inc;
  logic [7:0] rd_byte;
  logic [3:0] sa_type;

  assign sa_type = shift[i2c_port_pkg::SA_TYPE_HI:i2c_port_pkg::SA_TYPE_LO];
  assign ack_begin = scl_fall & ~ack_phase & (bcnt == i2c_port_pkg::BYTE_BITS)
                     & (state != i2c_port_pkg::ST_IDLE);
  assign ack_end = scl_fall & ack_phase;
  assign sa_match = ((sa_type == MEM_TYPE) || (sa_type == REG_TYPE))
                    && (shift[i2c_port_pkg::SA_SEL_HI:i2c_port_pkg::SA_SEL_LO] == sel_s);
  assign reg_bad = (state == i2c_port_pkg::ST_AHI) && rd_is_reg
                   && (shift > i2c_port_pkg::REG_ADDR_MAX);
  // Commit only once all eight bits are in; a full FIFO refuses the byte
  assign push = ack_begin && (state == i2c_port_pkg::ST_WR) && fifo_in_ready;
  assign load_mem = ack_begin && (state == i2c_port_pkg::ST_ALO);
  assign load_reg = ack_begin && (state == i2c_port_pkg::ST_AHI) && rd_is_reg && !reg_bad;
  assign inc = push || (ack_begin && (state == i2c_port_pkg::ST_RD));
  assign rd_byte = rd_is_reg ? reg_rdata : mem_rdata;
  assign give_ack = ack_begin && (
    ((state == i2c_port_pkg::ST_SLV) && sa_match) ||
    ((state == i2c_port_pkg::ST_AHI) && !reg_bad) ||
    (state == i2c_port_pkg::ST_ALO) || push);

  // Open-drain: only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= i2c_port_pkg::ST_IDLE;
      bcnt <= 4'h0;
      ack_phase <= 1'b0;
      shift <= 8'h00;
      addr_hi <= 8'h00;
      rw <= 1'b0;
      rd_is_reg <= 1'b0;
      nacked <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= i2c_port_pkg::ST_SLV;
      bcnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= i2c_port_pkg::ST_IDLE;
      bcnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl_rise && state != i2c_port_pkg::ST_IDLE) begin
      if (ack_phase) begin
        nacked <= sda_s;
      end else begin
        if (state != i2c_port_pkg::ST_RD) begin
          shift <= {shift[6:0], sda_s};
        end
        bcnt <= bcnt + 4'h1;
      end
    end else if (ack_begin) begin
      ack_phase <= 1'b1;
      sda_oe <= give_ack;
      // A refused byte leaves the line released until the next START
      if (!give_ack && state != i2c_port_pkg::ST_RD) begin
        state <= i2c_port_pkg::ST_IDLE;
        ack_phase <= 1'b0;
      end
      if (state == i2c_port_pkg::ST_SLV) begin
        rd_is_reg <= (sa_type == REG_TYPE);
        rw <= shift[i2c_port_pkg::SA_RW];
      end
      if (state == i2c_port_pkg::ST_AHI) begin
        addr_hi <= shift;
      end
    end else if (ack_end) begin
      ack_phase <= 1'b0;
      bcnt <= 4'h0;
      sda_oe <= 1'b0;
      unique case (state)
        i2c_port_pkg::ST_SLV: begin
          if (rw) begin
            state <= i2c_port_pkg::ST_RD;
            shift <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end else begin
            state <= i2c_port_pkg::ST_AHI;
          end
        end
        i2c_port_pkg::ST_AHI: begin
          state <= rd_is_reg ? i2c_port_pkg::ST_WR : i2c_port_pkg::ST_ALO;
        end
        i2c_port_pkg::ST_ALO: begin
          state <= i2c_port_pkg::ST_WR;
        end
        i2c_port_pkg::ST_WR: begin
          state <= i2c_port_pkg::ST_WR;
        end
        i2c_port_pkg::ST_RD: begin
          if (nacked) begin
            state <= i2c_port_pkg::ST_IDLE;
          end else begin
            shift <= rd_byte;
            sda_oe <= ~rd_byte[7];
          end
        end
        default: begin
          state <= i2c_port_pkg::ST_IDLE;
        end
      endcase
    end else if (scl_fall && state == i2c_port_pkg::ST_RD && !ack_phase
                 && bcnt != 4'h0) begin
      sda_oe <= ~shift[6];
      shift <= {shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Current address latches, one per target
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= i2c_port_pkg::MEM_ADDR_RST;
    end else if (load_mem) begin
      mem_addr <= {addr_hi[i2c_port_pkg::HI_BYTE_BITS-1:0], shift};
    end else if (inc && !rd_is_reg) begin
      mem_addr <= mem_addr + 15'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr <= i2c_port_pkg::REG_ADDR_RST;
    end else if (load_reg) begin
      reg_addr <= shift;
    end else if (inc && rd_is_reg) begin
      reg_addr <= reg_addr + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Write stream buffer
  // ----------------------------------------------------------------------
  i2c_port_pkg::wr_item_t item_in;
  assign item_in.to_reg = rd_is_reg;
  assign item_in.addr = rd_is_reg ? {7'h00, reg_addr} : mem_addr;
  assign item_in.data = shift;

  byte_fifo #(
    .WIDTH($bits(i2c_port_pkg::wr_item_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(ack_begin && state == i2c_port_pkg::ST_WR),
    .in_ready(fifo_in_ready),
    .in_data(item_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_item)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_start_resets;
    @(posedge clk) disable iff (!rst_n)
    start_det |=> (state == i2c_port_pkg::ST_SLV) && (bcnt == 4'h0) && !sda_oe;
  endproperty
  a_start_resets: assert property (p_start_resets) else $error("START not honoured");

  property p_stop_idle;
    @(posedge clk) disable iff (!rst_n)
    stop_det |=> (state == i2c_port_pkg::ST_IDLE) && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("STOP not honoured");

  property p_bad_reg_nack;
    @(posedge clk) disable iff (!rst_n)
    (ack_begin && reg_bad && !start_det && !stop_det) |=>
      (state == i2c_port_pkg::ST_IDLE) && !sda_oe && $stable(reg_addr);
  endproperty
  a_bad_reg_nack: assert property (p_bad_reg_nack) else $error("Bad register addr acked");

  property p_sel_mismatch;
    @(posedge clk) disable iff (!rst_n)
    (ack_begin && state == i2c_port_pkg::ST_SLV && !start_det && !stop_det
     && shift[i2c_port_pkg::SA_SEL_HI:i2c_port_pkg::SA_SEL_LO] != sel_s)
      |=> !sda_oe && (state == i2c_port_pkg::ST_IDLE);
  endproperty
  a_sel_mismatch: assert property (p_sel_mismatch) else $error("Foreign address acked");

  property p_write_ack;
    @(posedge clk) disable iff (!rst_n)
    (push && !start_det && !stop_det) |=> sda_oe && ack_phase;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("Data byte not acked");

  property p_commit_after_eighth;
    @(posedge clk) disable iff (!rst_n)
    push |-> (bcnt == 4'h8) && scl_fall && (state == i2c_port_pkg::ST_WR) ##1 wr_valid;
  endproperty
  a_commit_after_eighth: assert property (p_commit_after_eighth) else $error("Early commit");

  property p_mem_inc;
    @(posedge clk) disable iff (!rst_n)
    (inc && !rd_is_reg && !start_det && !stop_det) |=>
      mem_addr == $past(mem_addr) + 15'h0001;
  endproperty
  a_mem_inc: assert property (p_mem_inc) else $error("Memory address not incremented");

  property p_reg_inc;
    @(posedge clk) disable iff (!rst_n)
    (inc && rd_is_reg) |=> reg_addr == $past(reg_addr) + 8'h01;
  endproperty
  a_reg_inc: assert property (p_reg_inc) else $error("Register address not incremented");

  // Both address bytes land together, high byte's top bit dropped
  property p_mem_load;
    @(posedge clk) disable iff (!rst_n)
    load_mem |=>
      mem_addr == {$past(addr_hi[i2c_port_pkg::HI_BYTE_BITS-1:0]), $past(shift)};
  endproperty
  a_mem_load: assert property (p_mem_load) else $error("Memory address not loaded");

  property p_reg_keeps_mem;
    @(posedge clk) disable iff (!rst_n)
    (rd_is_reg && !load_mem) |=> $stable(mem_addr);
  endproperty
  a_reg_keeps_mem: assert property (p_reg_keeps_mem) else $error("Memory latch disturbed");

  property p_nack_release;
    @(posedge clk) disable iff (!rst_n)
    (ack_end && state == i2c_port_pkg::ST_RD && nacked && !start_det && !stop_det)
      |=> (!sda_oe && state != i2c_port_pkg::ST_RD) [*8];
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("Line driven after nack");

  property p_read_first_bit;
    @(posedge clk) disable iff (!rst_n)
    (ack_end && state == i2c_port_pkg::ST_SLV && rw && !start_det && !stop_det)
      |=> (state == i2c_port_pkg::ST_RD) && (sda_oe == ~$past(rd_byte[7]));
  endproperty
  a_read_first_bit: assert property (p_read_first_bit) else $error("Read did not start");

  c_mem_write: cover property (@(posedge clk) disable iff (!rst_n) push && !rd_is_reg);
  c_reg_write: cover property (@(posedge clk) disable iff (!rst_n) push && rd_is_reg);
  c_read_acked: cover property (@(posedge clk) disable iff (!rst_n)
    ack_end && state == i2c_port_pkg::ST_RD && !nacked);
  c_bad_reg: cover property (@(posedge clk) disable iff (!rst_n) ack_begin && reg_bad);

endmodule

// file: hdl/i2c_port_pkg.sv
// Shared constants, types and states of the two-wire dual-target slave port
package i2c_port_pkg;

  // ----------------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------------
  localparam int MEM_AW = 15;
  localparam int REG_AW = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] REG_ADDR_MAX = 8'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [MEM_AW-1:0] MEM_ADDR_RST = 15'h0000;
  localparam logic [REG_AW-1:0] REG_ADDR_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Slave address byte fields and high address byte width
  // ----------------------------------------------------------------------
  localparam int SA_TYPE_HI = 7;
  localparam int SA_TYPE_LO = 4;
  localparam int SA_SEL_HI = 2;
  localparam int SA_SEL_LO = 1;
  localparam int SA_RW = 0;
  localparam int HI_BYTE_BITS = 7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLV  = 3'b001,
    ST_AHI  = 3'b010,
    ST_ALO  = 3'b011,
    ST_WR   = 3'b100,
    ST_RD   = 3'b101
  } port_state_t;

  typedef struct packed {
    logic to_reg;
    logic [MEM_AW-1:0] addr;
    logic [7:0] data;
  } wr_item_t;

endpackage

// file: sim/i2c_master_model.sv
// Two-wire bus master model that drives the clock and data lines
`timescale 1ns/1ns
module i2c_master_model (
  // Clock
  input wire logic clk,
  // Bus
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // ------
  // Timing
  // ------
  // A quarter of the 64 ns bus period; the clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic q();
    repeat (4) @(posedge clk);
  endtask
  // ------
  // Bus conditions
  // ------
  // Starts from clock low too, so it serves as a repeated start
  task automatic start();
    sda_drv <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_drv <= 1'b1;
    q();
  endtask
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Eight bits then the acknowledge clock; a nack ends a read
  task automatic xfer(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx,
      output logic ak_out);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], b);
      rx[i] = b;
    end
    bit_io(ak_in, ak_out);
  endtask
endmodule

// file: sim/tb_i2c_dual_slave.sv
// Self-checking bench for the dual-target two-wire slave port
`timescale 1ns/1ns
module tb_i2c_dual_slave;
  // ------
  // Settings and rows
  // ------
  localparam logic [3:0] MT = 4'h6; // Arbitrary value
  localparam logic [3:0] RT = 4'h9; // Arbitrary value
  localparam logic [1:0] SEL = 2'b10;
  typedef struct {
    logic [14:0] a;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [14:0] ea;
  } row_t;
  row_t rows [3] = '{
    '{15'h0123, 8'ha5, 8'h3c, 15'h0125},
    '{15'h7fff, 8'h81, 8'h7e, 15'h0001},
    '{15'h4000, 8'h00, 8'hff, 15'h4002}};
  logic [5:0] bad [4] = '{{4'h5, SEL}, {MT, 2'b00}, {MT, 2'b11}, {RT, 2'b01}};
  // ------
  // Signals
  // ------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_drv, sda_out, sda_oe, rd_is_reg, wr_valid, ak;
  wire sda = sda_drv & (sda_oe ? sda_out : 1'b1);
  logic [1:0] dev_sel = SEL;
  logic [14:0] mem_addr;
  logic [7:0] reg_addr, rx, mem_rdata, reg_rdata;
  logic wr_ready = 1'b1;
  i2c_port_pkg::wr_item_t wr_item;
  logic [7:0] mem [0:32767];
  logic [7:0] regs [0:255];
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  assign mem_rdata = mem[mem_addr];
  assign reg_rdata = regs[reg_addr];
  // Consumer of the write stream stands in for the array and registers
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (wr_item.to_reg) regs[wr_item.addr[7:0]] <= wr_item.data;
      else mem[wr_item.addr] <= wr_item.data;
    end
  end
  i2c_dual_slave #(.MEM_TYPE(MT), .REG_TYPE(RT), .FIFO_DEPTH(16)) dut_u (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_sel(dev_sel), .mem_addr(mem_addr), .reg_addr(reg_addr),
    .rd_is_reg(rd_is_reg), .mem_rdata(mem_rdata), .reg_rdata(reg_rdata),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_item(wr_item));
  i2c_master_model m_u (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs some 11800 cycles
  always @(posedge clk) begin
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic sb(input logic [7:0] b);
    m_u.xfer(b, 1'b1, rx, ak);
  endtask
  task automatic rb(input logic nak);
    m_u.xfer(8'hff, nak, rx, ak);
  endtask
  // Leaves the last address byte's ack in ak for the caller
  task automatic load(input logic to_reg, input logic [14:0] a);
    m_u.start();
    sb({to_reg ? RT : MT, 1'b0, SEL, 1'b0});
    chk("slave ack", ak, 1'b0);
    if (!to_reg) sb({1'b1, a[14:8]});
    sb(a[7:0]);
  endtask
  task automatic rd_start(input logic to_reg);
    m_u.start();
    sb({to_reg ? RT : MT, 1'b0, SEL, 1'b1});
    chk("read ack", ak, 1'b0);
  endtask
  // ------
  // Sequence
  // ------
  initial begin
    repeat (16) @(posedge clk);
    chk("reset outs", {sda_oe, wr_valid, rd_is_reg, reg_addr}, 16'h0000);
    chk("reset addr", mem_addr, 16'h0000);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (rows[i]) begin
      load(1'b0, rows[i].a);
      chk("addr ack", ak, 1'b0);
      sb(rows[i].d0);
      chk("data ack", ak, 1'b0);
      sb(rows[i].d1);
      chk("data ack", ak, 1'b0);
      m_u.stop();
      load(1'b0, rows[i].a);
      rd_start(1'b0);
      rb(1'b0);
      chk("read d0", rx, rows[i].d0);
      rb(1'b1);
      chk("read d1", rx, rows[i].d1);
      m_u.stop();
      chk("mem addr", mem_addr, rows[i].ea);
      $display("row %0d done", i);
    end
    // Register target: boundary address, increment past it is not blocked
    load(1'b1, 15'h0018);
    chk("reg addr ack", ak, 1'b0);
    sb(8'h55);
    sb(8'h3a);
    m_u.stop();
    chk("reg addr", reg_addr, 8'h1a);
    chk("mem kept", mem_addr, 15'h4002);
    load(1'b1, 15'h0018);
    rd_start(1'b1);
    rb(1'b0);
    chk("reg d0", rx, 8'h55);
    rb(1'b1);
    chk("reg d1", rx, 8'h3a);
    m_u.stop();
    $display("register test done");
    // Just above the legal range is refused and abandoned
    load(1'b1, 15'h0019);
    chk("bad reg nack", ak, 1'b1);
    sb(8'h11);
    chk("abandoned", ak, 1'b1);
    m_u.stop();
    chk("reg kept", reg_addr, 8'h1a);
    foreach (bad[k]) begin
      m_u.start();
      sb({bad[k][5:2], 1'b0, bad[k][1:0], 1'b0});
      chk("foreign nack", ak, 1'b1);
      m_u.stop();
    end
    $display("refusal test done");
    // Start after seven data bits: nothing stored, read from loaded address
    load(1'b0, 15'h0123);
    for (int k = 0; k < 7; k++) m_u.bit_io(1'b0, ak);
    rd_start(1'b0);
    chk("no push", wr_valid, 1'b0);
    rb(1'b1);
    chk("read loaded", rx, 8'ha5);
    rb(1'b1);
    chk("released", rx, 8'hff);
    m_u.stop();
    chk("stop idle", sda_oe, 1'b0);
    $display("abort test done");
    // Consumer stalls: sixteen bytes fit, the next one is refused
    wr_ready <= 1'b0;
    load(1'b0, 15'h1000);
    for (int k = 0; k < 17; k++) begin
      sb(8'(k));
      chk("fill ack", ak, 16'(k == 16));
    end
    m_u.stop();
    wr_ready <= 1'b1;
    for (int k = 0; k < 60 && wr_valid !== 1'b0; k++) @(posedge clk);
    chk("drained", wr_valid, 1'b0);
    chk("last kept", mem[15'h100f], 8'h0f);
    $display("buffer test done");
    // Supply drop mid-run forgets both current addresses
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("drop mem addr", mem_addr, 16'h0000);
    chk("drop reg addr", reg_addr, 16'h0000);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd_start(1'b0);
    rb(1'b1);
    chk("read after drop", rx, 8'h7e);
    m_u.stop();
    $display("supply drop test done");
    give_verdict();
  end
endmodule
